// ==== hdl/mfc_pkg.sv ====
// mfc_pkg: register map, field positions, reset values and carrier types
// assumes: 32-bit register port with byte offsets, one core clock
package mfc_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int NCT = 3;
  localparam int NEDGE = 4;
  localparam int NWIN = 2;
  localparam int CT_MODE_W = 3;
  localparam int IRQ_W = 10;
  localparam int FUNC_W = 5;
  localparam int PRE_W = 2;
  localparam logic [PRE_W-1:0] PRE_LAST = 2'h3;
  localparam logic [AW-1:0] OFS_FUNC = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_IRQ_EN = 8'h08;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [AW-1:0] OFS_DIV = 8'h10;
  localparam logic [AW-1:0] OFS_MEAS = 8'h14;
  localparam logic [AW-1:0] OFS_TBASE = 8'h18;
  localparam logic [AW-1:0] OFS_GATE = 8'h1C;
  localparam logic [AW-1:0] OFS_DOUT = 8'h20;
  localparam logic [AW-1:0] OFS_EDGE_POL = 8'h24;
  localparam logic [AW-1:0] OFS_WIN_RES = 8'h28;
  localparam logic [AW-1:0] OFS_CT_MODE = 8'h30;
  localparam logic [AW-1:0] OFS_CT_COUNT = 8'h40;
  localparam logic [AW-1:0] OFS_EDGE_CNT = 8'h50;
  localparam int FUNC_LSB = 0;
  localparam int FUNC_CLKSEL = 2;
  localparam int FUNC_EXTCLK = 3;
  localparam int FUNC_EDGE_SET = 4;
  localparam int GATE_SW_LSB = 0;
  localparam int GATE_HW_LSB = 3;
  localparam int IRQ_CT_LSB = 0;
  localparam int IRQ_WIN_LSB = 3;
  localparam int IRQ_EDGE_LSB = 5;
  localparam int IRQ_SW_BIT = 9;
  localparam int ST_IN_LSB = 2;
  localparam logic [FUNC_W-1:0] FUNC_RST = 5'h00;
  localparam logic [DW-1:0] DIV_RST = 32'h0000_0009;
  localparam logic [CT_MODE_W-1:0] CT_M0 = 3'h0;
  localparam logic [CT_MODE_W-1:0] CT_M1 = 3'h1;
  localparam logic [CT_MODE_W-1:0] CT_M2 = 3'h2;
  localparam logic [CT_MODE_W-1:0] CT_M3 = 3'h3;
  localparam logic [CT_MODE_W-1:0] CT_M4 = 3'h4;
  localparam logic [CT_MODE_W-1:0] CT_M5 = 3'h5;
  typedef enum logic [1:0] {FN_STOPWATCH, FN_COUNTER, FN_WINDOW, FN_EDGE} mfc_func_t;
  typedef struct packed {logic g; logic f; logic e; logic d; logic c; logic b; logic a;} mfc_field_in_t;
  typedef struct packed {logic [1:0] oe; logic [2:0] lvl;} mfc_field_out_t;
endpackage : mfc_pkg

// ==== hdl/mfc_ct_channel.sv ====
// mfc_ct_channel: one binary down counter with six output modes
// assumes: tick, gate and strobes are on the core clock, one cycle pulses
`timescale 1ns/10ps
module mfc_ct_channel #(
  parameter int CNT_W = mfc_pkg::DW
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_gate,
  input wire logic i_cfg,
  input wire logic i_load,
  input wire logic [mfc_pkg::CT_MODE_W-1:0] i_mode,
  input wire logic [CNT_W-1:0] i_count,
  output logic [CNT_W-1:0] o_count,
  output logic o_out,
  output logic o_tc
);
  import mfc_pkg::*;

  if (CNT_W < 2) begin : g_bad_width
    $error("counter width below 2");
  end

  logic [CNT_W-1:0] reload_count_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic pend_ff, run_ff, wrap_ff, out_ff, tc_ff, gate_q_ff;
  logic trig_mode, gate_ok, low_start, gate_rise;

  assign trig_mode = (i_mode == CT_M1) || (i_mode == CT_M5);
  assign gate_ok = trig_mode || i_gate;
  assign low_start = (i_mode == CT_M0) || (i_mode == CT_M1);
  assign gate_rise = i_gate && !gate_q_ff;
  assign o_count = cnt_ff;
  assign o_out = out_ff;
  assign o_tc = tc_ff;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      gate_q_ff <= 1'b0;
      reload_count_ff <= '0;
    end else begin
      gate_q_ff <= i_gate;
      if (i_load) begin
        reload_count_ff <= i_count;
      end
    end
  end

  // a write arms the channel in modes 0, 2, 3 and 4, a gate rise in modes 1 and 5; the value lands on the next tick
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
      pend_ff <= 1'b0;
      run_ff <= 1'b0;
      wrap_ff <= 1'b0;
      out_ff <= 1'b0;
      tc_ff <= 1'b0;
    end else begin
      tc_ff <= 1'b0;
      if (i_cfg) begin
        out_ff <= !low_start;
        run_ff <= 1'b0;
        pend_ff <= 1'b0;
        wrap_ff <= 1'b0;
      end else if (i_load) begin
        pend_ff <= !trig_mode;
        out_ff <= !low_start;
      end else begin
        if (i_tick) begin
          if (pend_ff) begin
            cnt_ff <= reload_count_ff;
            pend_ff <= 1'b0;
            run_ff <= 1'b1;
            wrap_ff <= 1'b0;
            out_ff <= !low_start;
          end else if (wrap_ff) begin
            out_ff <= 1'b1;
            wrap_ff <= 1'b0;
          end else if (run_ff && gate_ok) begin
            case (i_mode)
              CT_M0, CT_M1: begin
                if (cnt_ff <= 1) begin
                  cnt_ff <= '0;
                  out_ff <= 1'b1;
                  tc_ff <= 1'b1;
                  run_ff <= 1'b0;
                end else begin
                  cnt_ff <= cnt_ff - 1'b1;
                end
              end
              CT_M2, CT_M3: begin
                // reload to value plus one so a period spans value plus two ticks
                if (cnt_ff == 0) begin
                  cnt_ff <= reload_count_ff + 1'b1;
                  out_ff <= 1'b1;
                end else begin
                  cnt_ff <= cnt_ff - 1'b1;
                  if (i_mode == CT_M2) begin
                    out_ff <= (cnt_ff != 1);
                  end else begin
                    out_ff <= (cnt_ff - 1'b1) > (reload_count_ff >> 1);
                  end
                  tc_ff <= (cnt_ff == 1);
                end
              end
              CT_M4, CT_M5: begin
                if (cnt_ff == 0) begin
                  out_ff <= 1'b0;
                  tc_ff <= 1'b1;
                  run_ff <= 1'b0;
                  wrap_ff <= 1'b1;
                end else begin
                  cnt_ff <= cnt_ff - 1'b1;
                end
              end
              default: begin
                cnt_ff <= cnt_ff;
              end
            endcase
          end
        end
        if (trig_mode && gate_rise) begin
          pend_ff <= 1'b1;
        end
      end
    end
  end

  AST_M0_HIGH_AT_END: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (tc_ff && low_start && !i_cfg && !i_load) |-> out_ff)
    else $error("mode 0 terminal count without high output");

  AST_M2_LOW_ONE_TICK: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_mode == CT_M2 && !out_ff && i_tick && run_ff && !pend_ff && i_gate && !i_cfg && !i_load) |=> out_ff)
    else $error("mode 2 low phase longer than one tick");

  sequence s_strobe_end;
    tc_ff && (i_mode == CT_M4) && !i_cfg && !i_load;
  endsequence
  AST_M4_STROBE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_strobe_end |-> !out_ff && wrap_ff)
    else $error("mode 4 strobe missing");

  AST_LOAD_NEXT_TICK: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (pend_ff && i_tick && !i_cfg && !i_load) |=> (cnt_ff == reload_count_ff))
    else $error("new count not taken on next tick");

  AST_GATE_HOLDS: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (run_ff && !pend_ff && !wrap_ff && !i_gate && !trig_mode && !i_cfg && !i_load && !gate_rise) |=> $stable(cnt_ff))
    else $error("counter moved with gate low");
endmodule : mfc_ct_channel

// ==== hdl/mfc_top.sv ====
// mfc_top: multifunction counter module, one function active at a time
// assumes: field pins and the 10 MHz source are asynchronous, host port on core clock
`timescale 1ns/10ps
module mfc_top (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [mfc_pkg::AW-1:0] i_addr,
  input wire logic [mfc_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [mfc_pkg::DW-1:0] o_rdata,
  input wire logic i_osc_10m,
  input wire mfc_pkg::mfc_field_in_t i_field,
  output mfc_pkg::mfc_field_out_t o_field,
  output logic o_irq
);
  import mfc_pkg::*;

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    return a == ofs;
  endfunction : hit

  // pins and oscillator: bits 0..6 are a..g, bit 7 is the 10 MHz source
  logic [7:0] sy1_ff, sy2_ff, sy3_ff;
  logic [7:0] pin_rise, pin_fall;
  logic [PRE_W-1:0] pre_ff;
  logic osc_tick, div4_tick, base_tick, ct_tick;

  logic [FUNC_W-1:0] func_ff;
  logic [DW-1:0] div_ff;
  logic [IRQ_W-1:0] ien_ff, ist_ff, irq_set;
  logic [2:0] sw_gate_ff, gsel_ff, dout_ff;
  logic [CT_MODE_W-1:0] ct_mode_ff [NCT];
  logic [NEDGE-1:0] edge_pol_ff;
  mfc_func_t fn;

  logic [DW-1:0] tb_ff;
  logic tb_pulse;
  logic [DW-1:0] meas_ff, sw_res_ff;
  logic sw_run_ff, sw_start, sw_stop;
  logic win_act_ff, win_start, win_stop;
  logic [DW-1:0] windowed_pulse_count_ff [NWIN];
  logic [DW-1:0] win_res_ff [NWIN];
  logic [DW-1:0] edge_cnt_ff [NEDGE];
  logic [NEDGE-1:0] edge_ev, edge_wr, edge_zero;
  logic edge_out_ff;

  logic [NCT-1:0] ct_out, ct_tc, gate_vec;
  logic [DW-1:0] ct_count [NCT];

  logic [DW-1:0] rd_val, rdata_ff;
  mfc_field_out_t field_ff;
  logic irq_ff;

  assign fn = mfc_func_t'(func_ff[FUNC_LSB +: 2]);
  assign o_rdata = rdata_ff;
  assign o_field = field_ff;
  assign o_irq = irq_ff;

  // the first stage feeds only the second; edges compare stage two and three
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sy1_ff <= 8'h00;
      sy2_ff <= 8'h00;
      sy3_ff <= 8'h00;
    end else begin
      sy1_ff <= {i_osc_10m, i_field};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  assign pin_rise = sy2_ff & ~sy3_ff;
  assign pin_fall = ~sy2_ff & sy3_ff;
  assign osc_tick = pin_rise[7];

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  assign div4_tick = (pre_ff == PRE_LAST);
  assign base_tick = func_ff[FUNC_CLKSEL] ? osc_tick : 1'b1;
  assign ct_tick = func_ff[FUNC_CLKSEL] ? osc_tick : div4_tick;

  // host-written control registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      func_ff <= FUNC_RST;
      div_ff <= DIV_RST;
      ien_ff <= '0;
      sw_gate_ff <= '0;
      gsel_ff <= '0;
      dout_ff <= '0;
      edge_pol_ff <= '0;
    end else if (i_wr) begin
      if (hit(i_addr, OFS_FUNC)) func_ff <= i_wdata[FUNC_W-1:0];
      if (hit(i_addr, OFS_DIV)) div_ff <= i_wdata;
      if (hit(i_addr, OFS_IRQ_EN)) ien_ff <= i_wdata[IRQ_W-1:0];
      if (hit(i_addr, OFS_GATE)) begin
        sw_gate_ff <= i_wdata[GATE_SW_LSB +: 3];
        gsel_ff <= i_wdata[GATE_HW_LSB +: 3];
      end
      if (hit(i_addr, OFS_DOUT)) dout_ff <= i_wdata[2:0];
      if (hit(i_addr, OFS_EDGE_POL)) edge_pol_ff <= i_wdata[NEDGE-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < NCT; k++) ct_mode_ff[k] <= CT_M0;
    end else if (i_wr) begin
      for (int k = 0; k < NCT; k++) begin
        if (hit(i_addr, OFS_CT_MODE + AW'(4 * k))) ct_mode_ff[k] <= i_wdata[CT_MODE_W-1:0];
      end
    end
  end

  // time base: reading it never touches it; a start event restarts it
  assign sw_start = (fn == FN_STOPWATCH) && pin_rise[2];
  assign sw_stop = (fn == FN_STOPWATCH) && pin_rise[3] && sw_run_ff && !sw_start;
  assign tb_pulse = base_tick && (tb_ff == 0) && !sw_start;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tb_ff <= DIV_RST;
    end else if (sw_start) begin
      tb_ff <= div_ff;
    end else if (base_tick) begin
      tb_ff <= (tb_ff == 0) ? div_ff : tb_ff - 1'b1;
    end
  end

  // stopwatch measuring timer
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meas_ff <= '0;
      sw_res_ff <= '0;
      sw_run_ff <= 1'b0;
    end else if (sw_start) begin
      meas_ff <= '0;
      sw_run_ff <= 1'b1;
    end else if (sw_stop) begin
      sw_res_ff <= meas_ff;
      sw_run_ff <= 1'b0;
    end else if (sw_run_ff && tb_pulse) begin
      meas_ff <= meas_ff + 1'b1;
    end
  end

  // window: software gate bit 0 runs it, each time-base pulse toggles start/stop
  assign win_start = (fn == FN_WINDOW) && sw_gate_ff[0] && tb_pulse && !win_act_ff;
  assign win_stop = (fn == FN_WINDOW) && tb_pulse && win_act_ff;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      win_act_ff <= 1'b0;
      for (int k = 0; k < NWIN; k++) begin
        windowed_pulse_count_ff[k] <= '0;
        win_res_ff[k] <= '0;
      end
    end else begin
      if (win_start) win_act_ff <= 1'b1;
      if (win_stop) win_act_ff <= 1'b0;
      for (int k = 0; k < NWIN; k++) begin
        if (win_start) begin
          windowed_pulse_count_ff[k] <= '0;
        end else if (win_stop) begin
          win_res_ff[k] <= windowed_pulse_count_ff[k];
        end else if (win_act_ff && pin_rise[k]) begin
          windowed_pulse_count_ff[k] <= windowed_pulse_count_ff[k] + 1'b1;
        end
      end
    end
  end

  // edge counters: a preload write beats an edge in the same cycle
  always_comb begin
    for (int k = 0; k < NEDGE; k++) begin
      edge_ev[k] = (fn == FN_EDGE) && (edge_pol_ff[k] ? pin_fall[k] : pin_rise[k]);
      edge_wr[k] = i_wr && hit(i_addr, OFS_EDGE_CNT + AW'(4 * k));
      edge_zero[k] = edge_ev[k] && !edge_wr[k] && (edge_cnt_ff[k] == 1);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < NEDGE; k++) edge_cnt_ff[k] <= '0;
    end else begin
      for (int k = 0; k < NEDGE; k++) begin
        if (edge_wr[k]) begin
          edge_cnt_ff[k] <= i_wdata;
        end else if (edge_ev[k] && edge_cnt_ff[k] != 0) begin
          edge_cnt_ff[k] <= edge_cnt_ff[k] - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      edge_out_ff <= 1'b0;
    end else if (|edge_zero) begin
      edge_out_ff <= func_ff[FUNC_EDGE_SET];
    end
  end

  // counter/timer channels; channel 0 never takes a field pin as clock, only the div4 tick or the 10 MHz source
  for (genvar k = 0; k < NCT; k++) begin : g_ct
    logic tick_k;
    assign gate_vec[k] = gsel_ff[k] ? sy2_ff[4 + k] : sw_gate_ff[k];
    if (k == 0) begin : g_int
      assign tick_k = (fn == FN_COUNTER) && ct_tick;
    end else begin : g_ext
      assign tick_k = (fn == FN_COUNTER) && (func_ff[FUNC_EXTCLK] ? pin_rise[1 + k] : ct_tick);
    end
    mfc_ct_channel #(.CNT_W(DW)) u_ct (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_tick(tick_k),
      .i_gate(gate_vec[k]),
      .i_cfg(i_wr && hit(i_addr, OFS_CT_MODE + AW'(4 * k))),
      .i_load(i_wr && hit(i_addr, OFS_CT_COUNT + AW'(4 * k))),
      .i_mode(ct_mode_ff[k]),
      .i_count(i_wdata),
      .o_count(ct_count[k]),
      .o_out(ct_out[k]),
      .o_tc(ct_tc[k])
    );
  end

  // sticky status: a new event wins over a write-one clear in the same cycle
  assign irq_set = {sw_stop, edge_zero, {NWIN{win_stop}}, ct_tc};

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ist_ff <= '0;
    end else begin
      if (i_wr && hit(i_addr, OFS_IRQ_STAT)) begin
        ist_ff <= (ist_ff & ~i_wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        ist_ff <= ist_ff | irq_set;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(ist_ff & ien_ff);
    end
  end

  always_comb begin
    rd_val = '0;
    case (i_addr)
      OFS_FUNC: rd_val = DW'(func_ff);
      OFS_STATUS: rd_val = DW'({gate_vec, ct_out, ~sy2_ff[6:4], win_act_ff, sw_run_ff});
      OFS_IRQ_EN: rd_val = DW'(ien_ff);
      OFS_IRQ_STAT: rd_val = DW'(ist_ff);
      OFS_DIV: rd_val = div_ff;
      OFS_MEAS: rd_val = sw_res_ff;
      OFS_TBASE: rd_val = tb_ff;
      OFS_GATE: rd_val = DW'({gsel_ff, sw_gate_ff});
      OFS_DOUT: rd_val = DW'(dout_ff);
      OFS_EDGE_POL: rd_val = DW'(edge_pol_ff);
      default: rd_val = '0;
    endcase
    for (int k = 0; k < NCT; k++) begin
      if (hit(i_addr, OFS_CT_MODE + AW'(4 * k))) rd_val = DW'(ct_mode_ff[k]);
      if (hit(i_addr, OFS_CT_COUNT + AW'(4 * k))) rd_val = ct_count[k];
    end
    for (int k = 0; k < NWIN; k++) begin
      if (hit(i_addr, OFS_WIN_RES + AW'(4 * k))) rd_val = win_res_ff[k];
    end
    for (int k = 0; k < NEDGE; k++) begin
      if (hit(i_addr, OFS_EDGE_CNT + AW'(4 * k))) rd_val = edge_cnt_ff[k];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= i_rd ? rd_val : '0;
    end
  end

  // pins a and b are outputs only while the active function drives them
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      field_ff <= '0;
    end else begin
      case (fn)
        FN_STOPWATCH: field_ff <= '{oe: 2'h3, lvl: dout_ff};
        FN_COUNTER: field_ff <= '{oe: 2'h3, lvl: ct_out};
        FN_WINDOW: field_ff <= '{oe: 2'h0, lvl: {dout_ff[2], 2'h0}};
        FN_EDGE: field_ff <= '{oe: 2'h0, lvl: {edge_out_ff, 2'h0}};
        default: field_ff <= '0;
      endcase
    end
  end

  AST_SW_STORE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    sw_stop |=> (sw_res_ff == $past(meas_ff)) && !sw_run_ff)
    else $error("stopwatch result not stored");

  AST_TB_RELOAD: assert property (@(posedge i_core_clk) disable iff (i_reset)
    tb_pulse |=> (tb_ff == $past(div_ff)))
    else $error("time base not reloaded from divider");

  AST_TB_SYNC: assert property (@(posedge i_core_clk) disable iff (i_reset)
    sw_start |=> (tb_ff == $past(div_ff)) && sw_run_ff && (meas_ff == 0))
    else $error("time base not restarted by start");

  AST_SW_OUT: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (fn == FN_STOPWATCH) |=> (field_ff.lvl == $past(dout_ff)))
    else $error("stopwatch outputs differ from output register");

  AST_IN_INVERT: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd && i_addr == OFS_STATUS) |=> (rdata_ff[ST_IN_LSB +: 3] == ~$past(sy2_ff[6:4])))
    else $error("inputs not read inverted");

  AST_CT_IRQ: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ct_tc[0] |=> ist_ff[IRQ_CT_LSB])
    else $error("counter event lost");

  sequence s_win_stop;
    win_stop;
  endsequence
  AST_WIN_STOP: assert property (@(posedge i_core_clk) disable iff (i_reset)
    s_win_stop |=> !win_act_ff && (win_res_ff[0] == $past(windowed_pulse_count_ff[0])) && ist_ff[IRQ_WIN_LSB])
    else $error("window stop not handled");

  AST_EDGE_ZERO: assert property (@(posedge i_core_clk) disable iff (i_reset)
    edge_zero[0] |=> ist_ff[IRQ_EDGE_LSB] && (edge_cnt_ff[0] == 0))
    else $error("edge counter zero not flagged");
endmodule : mfc_top

// ==== sim/mfc_field_model.sv ====
// mfc_field_model: field side pins, one pulse source plus static levels on E, F, G
// assumes: requests arrive on the core clock as one cycle strobes
`timescale 1ns/10ps
module mfc_field_model (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_pulse,
  input wire logic [1:0] i_pin,
  input wire logic [2:0] i_efg,
  output mfc_pkg::mfc_field_in_t o_field
);
  import mfc_pkg::*;
  logic [1:0] sel_ff;
  logic [2:0] cnt_ff;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_ff <= 2'h0;
      cnt_ff <= 3'h0;
    end else if (i_pulse) begin
      sel_ff <= i_pin;
      cnt_ff <= 3'h6;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  // three cycles high, then three low, so the sync stage never misses an edge
  always_comb begin
    o_field = {i_efg, 4'h0};
    if (cnt_ff > 3'h3) begin
      o_field[sel_ff] = 1'b1;
    end
  end
endmodule : mfc_field_model

// ==== sim/tb_mfc_top.sv ====
// tb_mfc_top: register port driver, read scoreboard and field model around mfc_top
// assumes: counter ticks at bus clock div4 unless a test selects the 10 MHz source
`timescale 1ns/10ps
module tb_mfc_top;
  import mfc_pkg::*;
  logic i_core_clk, i_reset, i_wr, i_rd, i_osc_10m, o_irq, pulse, rd_ff;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata, o_rdata, m_cur, exp_q[$], msk_q[$];
  logic [1:0] pin;
  logic [2:0] efg;
  mfc_field_in_t i_field;
  mfc_field_out_t o_field;
  int n_fail, num_checks, seed, n, k, k2;
  mfc_top i_mfc_top (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_10m(i_osc_10m), .i_field(i_field),
    .o_field(o_field), .o_irq(o_irq));
  mfc_field_model i_mfc_field_model (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_pulse(pulse),
    .i_pin(pin), .i_efg(efg), .o_field(i_field));
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_osc_10m = 1'b0;
    forever #50 i_osc_10m = ~i_osc_10m;
  end
  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr
  // expected word and mask are queued here, the monitor compares them
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask : rd
  task automatic wait_lvl(input int b, input logic v, output int c);
    c = 0;
    while (o_field.lvl[b] !== v && c < 2000) begin
      @(posedge i_core_clk);
      c++;
    end
  endtask : wait_lvl
  task automatic fire(input logic [1:0] p);
    pulse <= 1'b1;
    pin <= p;
    @(posedge i_core_clk);
    pulse <= 1'b0;
    repeat (10) @(posedge i_core_clk);
  endtask : fire
  always @(posedge i_core_clk) begin
    rd_ff <= i_rd;
    // mask popped first so both operands use the same queue entry
    if (rd_ff) begin
      m_cur = msk_q.pop_front();
      check(o_rdata & m_cur, exp_q.pop_front() & m_cur);
    end
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {i_reset, i_wr, i_rd, pulse} = 4'h8;
    {i_addr, i_wdata, pin, efg} = '0;
    seed = 27789;
    repeat (5) @(posedge i_core_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    check({27'h0, o_field}, 32'h18);
    rd(OFS_DIV, DIV_RST, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0, 32'hFFFF_FFFF);
    n = $random(seed);
    wr(OFS_DIV, n);
    rd(OFS_DIV, n, 32'hFFFF_FFFF);
    efg <= 3'h5;
    repeat (6) @(posedge i_core_clk);
    rd(OFS_STATUS, 32'h8, 32'h1C);
    $display("test reset and inputs done");
    wr(OFS_FUNC, 32'h1);
    wr(OFS_IRQ_EN, 32'h7);
    wr(OFS_GATE, 32'h0);
    wr(OFS_CT_MODE, {29'h0, CT_M0});
    n = 2 + ($random(seed) & 7);
    wr(OFS_CT_COUNT, n);
    repeat (8 * n) @(posedge i_core_clk);
    check({31'h0, o_field.lvl[0]}, 32'h0);
    wr(OFS_GATE, 32'h7);
    wait_lvl(0, 1'b1, k);
    check({31'h0, k >= 4 * n && k <= 4 * n + 12}, 32'h1);
    repeat (2) @(posedge i_core_clk);
    check({31'h0, o_irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h1, 32'h7);
    wr(OFS_IRQ_STAT, 32'h7);
    rd(OFS_IRQ_STAT, 32'h0, 32'h7);
    check({31'h0, o_irq}, 32'h0);
    $display("test mode 0 done");
    wr(OFS_CT_MODE, {29'h0, CT_M2});
    n = 3 + ($random(seed) & 3);
    wr(OFS_CT_COUNT, n);
    repeat (2) begin
      wait_lvl(0, 1'b0, k);
      wait_lvl(0, 1'b1, k);
    end
    wait_lvl(0, 1'b0, k);
    wait_lvl(0, 1'b1, k);
    wait_lvl(0, 1'b0, k2);
    check(k, 32'h4);
    check(k + k2, 4 * (n + 2));
    wr(OFS_FUNC, 32'h5);
    wait_lvl(0, 1'b1, k);
    wait_lvl(0, 1'b0, k);
    wait_lvl(0, 1'b1, k);
    check({31'h0, k >= 12 && k <= 13}, 32'h1);
    $display("test mode 2 done");
    wr(OFS_FUNC, 32'h1);
    wr(OFS_CT_MODE, {29'h0, CT_M3});
    wr(OFS_CT_COUNT, 32'h4);
    wait_lvl(0, 1'b0, k);
    wait_lvl(0, 1'b1, k);
    wait_lvl(0, 1'b0, k2);
    check(k, 32'hC);
    check(k2, 32'hC);
    wr(OFS_CT_MODE, {29'h0, CT_M4});
    wr(OFS_CT_COUNT, 32'h40);
    repeat (20) @(posedge i_core_clk);
    wr(OFS_CT_COUNT, 32'h2);
    wait_lvl(0, 1'b0, k);
    check({31'h0, k >= 14 && k <= 17}, 32'h1);
    wait_lvl(0, 1'b1, k);
    check(k, 32'h4);
    $display("test modes 3 and 4 done");
    wr(OFS_FUNC, 32'h0);
    wr(OFS_DIV, 32'h1);
    wr(OFS_DOUT, 32'h5);
    // start and stop edges land 11 cycles apart: five time-base pulses
    fire(2'h2);
    fire(2'h3);
    rd(OFS_MEAS, 32'h5, 32'hFFFF_FFFF);
    rd(OFS_IRQ_STAT, 32'h200, 32'h200);
    rd(OFS_TBASE, 32'h0, 32'hFFFF_FFFE);
    check({27'h0, o_field}, 32'h1D);
    $display("test stopwatch done");
    wr(OFS_IRQ_EN, 32'h8);
    wr(OFS_IRQ_STAT, 32'h3FF);
    wr(OFS_DIV, 32'hC7);
    wr(OFS_FUNC, 32'h2);
    // first stop aligns the bench; the next window opens about 200 cycles later
    while (o_irq !== 1'b1) @(posedge i_core_clk);
    wr(OFS_IRQ_STAT, 32'h3FF);
    repeat (210) @(posedge i_core_clk);
    repeat (3) fire(2'h0);
    rd(OFS_STATUS, 32'h2, 32'h2);
    while (o_irq !== 1'b1) @(posedge i_core_clk);
    rd(OFS_WIN_RES, 32'h3, 32'hFFFF_FFFF);
    rd(OFS_WIN_RES + 8'h04, 32'h0, 32'hFFFF_FFFF);
    $display("test window done");
    wr(OFS_FUNC, 32'h13);
    wr(OFS_EDGE_POL, 32'h0);
    wr(OFS_IRQ_STAT, 32'h3FF);
    wr(OFS_EDGE_CNT, 32'h3);
    repeat (2) fire(2'h0);
    check({31'h0, o_field.lvl[2]}, 32'h0);
    fire(2'h0);
    check({31'h0, o_field.lvl[2]}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h20, 32'h20);
    $display("test edge counter done");
    tally_and_finish();
  end
endmodule : tb_mfc_top
